// ---- design/clock_prescaler.v ----
// Purpose: Oscillator divider chain with divide-by-two stage and power-of-two taps.
// Assumes: pclk is the oscillator; inputs synchronous.
// Notes: tick[k] pulses once every 2**k oscillator periods while run is high.
`timescale 1ns/100ps
`include "interval_timer_defines.vh"
module clock_prescaler #(
  parameter DIV_W = 12
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire run,
  input wire restart,
  // Taps
  output wire [DIV_W:0] tick,
  output wire half_phase,
  output wire quarter_clk
);

  reg [DIV_W-1:0] chain;
  reg half;
  genvar k;

  // ----------------------------------------
  // Divide-by-two stage and chain
  // ----------------------------------------
  // Half toggles beside the chain, not ahead of it; both step on each pclk rising edge while run is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half <= 1'b0;
      chain <= {DIV_W{1'b0}};
    end else if (restart) begin
      half <= 1'b0;
      chain <= {DIV_W{1'b0}};
    end else if (run) begin
      half <= ~half;
      chain <= chain + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  assign tick[0] = run & ~restart;
  generate
    for (k = 1; k <= DIV_W; k = k + 1) begin : g_tap
      assign tick[k] = run & ~restart & (&chain[k-1:0]);
    end
  endgenerate

  assign half_phase = half;
  assign quarter_clk = chain[`XOUT_DIV_BIT];

endmodule // clock_prescaler

// ---- design/edge_pulse.v ----
// Purpose: One-cycle pulse on each rising edge of a level input.
// Assumes: Input is synchronous to pclk.
// Notes: Pulse is suppressed while enable is low.
`timescale 1ns/100ps
module edge_pulse (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Level in, pulse out
  input wire enable,
  input wire level_in,
  output wire pulse
);

  reg level_prev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_prev <= 1'b0;
    end else begin
      level_prev <= level_in;
    end
  end

  assign pulse = enable & level_in & ~level_prev;

endmodule // edge_pulse

// ---- design/interval_timer_prescaler.v ----
// Purpose: 8-bit free-running interval timer with prescaler, APB slave.
// Assumes: pclk is the oscillator; pins synchronous to pclk.
// Notes: Count and control share one index; read gives count, write sets control.
// Notes: The watchdog counter lives outside; only its tick, its mode bit and rc_wdt_active leave here.
// Notes: With no core inside, stop is requested through the auxiliary register.
// Notes: Stop ends only through the stop_release pin, which wins over a new request.
`timescale 1ns/100ps
`include "interval_timer_defines.vh"
module interval_timer_prescaler #(
  parameter COUNT_W = `COUNT_W,
  parameter DIV_W = `PERIPH_DIV_W
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`APB_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Oscillator related pins
  input wire rc_osc_in,
  input wire ext_rc_mode,
  input wire stop_release,
  output reg xout_clk,
  // Timer events and watchdog link
  output reg interval_irq,
  output reg watchdog_tick,
  output reg watchdog_mode,
  output reg rc_wdt_active,
  // Peripheral clock enables
  output reg [DIV_W:0] periph_tick
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [COUNT_W-1:0] interval_count_value;
  reg [2:0] tap_select;
  reg counter_clear_bit;
  reg watchdog_mode_bit;
  reg rc_clock_select;
  reg interval_irq_flag;
  reg interval_irq_enable;
  reg stop_active;
  reg xout_enable;

  wire [DIV_W:0] tick;
  wire half_phase;
  wire quarter_clk;
  wire rc_pulse;
  wire access;
  wire wr_ctl;
  wire wr_aux;
  wire hit_ctl;
  wire hit_aux;
  wire prescale_pulse;
  wire count_pulse;
  wire wrap;
  wire clear_now;
  wire osc_run;
  wire [7:0] aux_read;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // One wait state so that pready and prdata come from flip-flops.
  // Cost: every access takes three cycles; the gain is no path from
  // paddr to prdata within one cycle.
  // Writes land only at the edge where pready is seen high.
  assign access = psel & penable & pready;
  assign hit_ctl = (paddr == `ADDR_COUNT_CONTROL);
  assign hit_aux = (paddr == `ADDR_AUX_CONTROL);
  assign wr_ctl = access & pwrite & hit_ctl;
  assign wr_aux = access & pwrite & hit_aux;

  assign aux_read = {3'h0, xout_enable, rc_wdt_active, stop_active, interval_irq_enable, interval_irq_flag};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~(hit_ctl | hit_aux);
      if (pwrite || !(hit_ctl || hit_aux)) begin
        prdata <= 32'h00000000;
      end else if (hit_ctl) begin
        // Reading this index shows the count, never the control bits
        prdata <= {{(32-COUNT_W){1'b0}}, interval_count_value};
      end else begin
        prdata <= {24'h000000, aux_read};
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Whole-byte write only; no read-modify-write is possible here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_select <= 3'h0;
      watchdog_mode_bit <= 1'b0;
      rc_clock_select <= 1'b0;
      counter_clear_bit <= 1'b0;
    end else if (wr_ctl) begin
      tap_select <= pwdata[`CTL_TAP_MSB:`CTL_TAP_LSB];
      watchdog_mode_bit <= pwdata[`CTL_WDT_MODE_BIT];
      rc_clock_select <= pwdata[`CTL_RC_SELECT_BIT];
      counter_clear_bit <= pwdata[`CTL_CLEAR_BIT];
    end else if (counter_clear_bit && half_phase) begin
      // Machine cycle is two oscillator periods
      counter_clear_bit <= 1'b0;
    end
  end

  // ----------------------------------------
  // Auxiliary register and stop state
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_irq_enable <= 1'b0;
      xout_enable <= 1'b0;
      stop_active <= 1'b0;
    end else begin
      if (wr_aux) begin
        interval_irq_enable <= pwdata[`AUX_IRQ_ENABLE_BIT];
        xout_enable <= pwdata[`AUX_XOUT_ENABLE_BIT];
      end
      if (stop_release) begin
        stop_active <= 1'b0;
      end else if (wr_aux && pwdata[`AUX_STOP_BIT]) begin
        stop_active <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Interval interrupt flag
  // ----------------------------------------
  // Set wins over a software clear in the same cycle,
  // so an overflow is never lost to a late acknowledge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_irq_flag <= 1'b0;
    end else if (wrap) begin
      interval_irq_flag <= 1'b1;
    end else if (wr_aux && pwdata[`AUX_IRQ_FLAG_BIT]) begin
      interval_irq_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Prescaler and RC source
  // ----------------------------------------
  // Stop halts the system oscillator chain and all peripheral clocks
  assign osc_run = ~stop_active;
  assign clear_now = wr_ctl & pwdata[`CTL_CLEAR_BIT];

  clock_prescaler #(
    .DIV_W(DIV_W)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .run(osc_run),
    .restart(clear_now),
    .tick(tick),
    .half_phase(half_phase),
    .quarter_clk(quarter_clk)
  );

  // RC source keeps running in stop, so RC watchdog mode survives.
  // Limitation: the RC level is sampled by pclk, so RC edges
  // closer than two pclk periods are merged.
  edge_pulse u_rc_edge (
    .pclk(pclk),
    .presetn(presetn),
    .enable(rc_clock_select),
    .level_in(rc_osc_in),
    .pulse(rc_pulse)
  );

  assign prescale_pulse = tick[`TAP_BASE_SHIFT + tap_select];
  assign count_pulse = rc_clock_select ? rc_pulse : prescale_pulse;
  assign wrap = count_pulse & ~clear_now & (interval_count_value == `COUNT_MAX);

  // ----------------------------------------
  // Interval counter
  // ----------------------------------------
  // No enable from software: only clear and the source clock affect it.
  // Clear wins over a count pulse in the same cycle, so the first
  // period after a clear is a full one when the prescaler is the source.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_count_value <= `COUNT_RESET;
    end else if (clear_now) begin
      interval_count_value <= `COUNT_RESET;
    end else if (count_pulse) begin
      interval_count_value <= interval_count_value + {{(COUNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Every output leaves from a flip-flop, one cycle behind its source.
  // Consumers of watchdog_tick see it one cycle after the wrap.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_irq <= 1'b0;
      watchdog_tick <= 1'b0;
      watchdog_mode <= 1'b0;
      rc_wdt_active <= 1'b0;
      periph_tick <= {(DIV_W+1){1'b0}};
      xout_clk <= 1'b0;
    end else begin
      interval_irq <= interval_irq_flag & interval_irq_enable;
      // One tick per overflow, so the watchdog period is (compare+1) overflows
      watchdog_tick <= wrap;
      watchdog_mode <= watchdog_mode_bit;
      rc_wdt_active <= stop_active & rc_clock_select;
      periph_tick <= tick;
      xout_clk <= ext_rc_mode & xout_enable & osc_run & quarter_clk;
    end
  end

endmodule // interval_timer_prescaler

// ---- inc/interval_timer_defines.vh ----
// Purpose: Constants for the interval timer with prescaler.
// Assumes: Included by bare name; definitions only.
// Notes: Byte address of a register is four times its index.
`ifndef INTERVAL_TIMER_DEFINES_VH
`define INTERVAL_TIMER_DEFINES_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define IDX_COUNT_CONTROL 8'hF2
`define IDX_AUX_CONTROL 8'hF3
`define ADDR_COUNT_CONTROL 12'h3C8
`define ADDR_AUX_CONTROL 12'h3CC
`define APB_ADDR_W 12

// ----------------------------------------
// clock_timer_control fields
// ----------------------------------------
`define CTL_TAP_LSB 0
`define CTL_TAP_MSB 2
`define CTL_CLEAR_BIT 3
`define CTL_WDT_MODE_BIT 4
`define CTL_RC_SELECT_BIT 5
`define CTL_RESET 8'h00

// ----------------------------------------
// Auxiliary control and status fields
// ----------------------------------------
`define AUX_IRQ_FLAG_BIT 0
`define AUX_IRQ_ENABLE_BIT 1
`define AUX_STOP_BIT 2
`define AUX_RC_WDT_BIT 3
`define AUX_XOUT_ENABLE_BIT 4
`define AUX_RESET 8'h00

// ----------------------------------------
// Counts
// ----------------------------------------
`define COUNT_W 8
`define COUNT_RESET 8'h00
`define COUNT_MAX 8'hFF
`define TAP_BASE_SHIFT 3
`define PERIPH_DIV_W 12
`define XOUT_DIV_BIT 1

`endif

// ---- verif/interval_timer_prescaler_sva.sv ----
// Purpose: Port checker for the interval timer.
// Assumes: Bound to the top module, one clock domain.
// Notes: Write effects are checked two edges later to allow a registered copy.
`timescale 1ns/100ps
`include "interval_timer_defines.vh"
module interval_timer_prescaler_sva #(
  parameter COUNT_W = 8,
  parameter DIV_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic rc_osc_in,
  input wire logic ext_rc_mode,
  input wire logic stop_release,
  input wire logic xout_clk,
  input wire logic interval_irq,
  input wire logic watchdog_tick,
  input wire logic watchdog_mode,
  input wire logic rc_wdt_active,
  input wire logic [DIV_W:0] periph_tick
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && pready;
  wire logic mapped = paddr == `ADDR_COUNT_CONTROL || paddr == `ADDR_AUX_CONTROL;

  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  ready_wait_a: assert property (psel && $rose(penable) |=> pready) else $error("pready late");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr) else $error("no error on hole");
  read_upper_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  mode_bit_a: assert property (acc && pwrite && paddr == `ADDR_COUNT_CONTROL |->
    ##2 watchdog_mode == $past(pwdata[4], 2)) else $error("mode bit wrong");
  tick_single_a: assert property (watchdog_tick |=> !watchdog_tick) else $error("tick too long");
  stop_gate_a: assert property (rc_wdt_active |-> periph_tick == '0) else $error("clock in stop");
  div_tick_a: assert property (periph_tick[2] |=> !periph_tick[2] [*3]) else $error("tap 2 fast");
  xout_high_a: assert property ($rose(xout_clk) |-> ##2 !xout_clk) else $error("xout too fast");
  reset_clear_a: assert property ($rose(presetn) |-> !pready && !interval_irq && !watchdog_mode
    && !rc_wdt_active) else $error("output set after reset");

  cover property (acc && pwrite);
  cover property (acc && pslverr);
  cover property (watchdog_tick);
  cover property (rc_wdt_active);
endmodule // interval_timer_prescaler_sva

bind interval_timer_prescaler interval_timer_prescaler_sva #(.COUNT_W(COUNT_W), .DIV_W(DIV_W)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rc_osc_in(rc_osc_in),
  .ext_rc_mode(ext_rc_mode), .stop_release(stop_release), .xout_clk(xout_clk), .interval_irq(interval_irq),
  .watchdog_tick(watchdog_tick), .watchdog_mode(watchdog_mode), .rc_wdt_active(rc_wdt_active),
  .periph_tick(periph_tick)
);

// ---- verif/interval_timer_prescaler_tb_top.sv ----
// Purpose: Self-checking bench for the interval timer.
// Assumes: APB answers with one wait state; pclk is the oscillator.
// Notes: Count reads are timed mid-period so one cycle of latency cannot flip them.
`timescale 1ns/100ps
`include "interval_timer_defines.vh"
module interval_timer_prescaler_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic rc_osc_in = 1'b0, ext_rc_mode = 1'b0, stop_release = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, xout_clk, interval_irq, watchdog_tick, watchdog_mode, rc_wdt_active;
  wire [12:0] periph_tick;
  int errors = 0, checks = 0, cycles = 0, n, m;
  logic [31:0] rd;
  logic er;

  interval_timer_prescaler i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rc_osc_in, .ext_rc_mode, .stop_release, .xout_clk, .interval_irq, .watchdog_tick,
    .watchdog_mode, .rc_wdt_active, .periph_tick);

  initial begin
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic final_report;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, x);
  endtask

  task automatic rc_pulse;
    @(posedge pclk);
    rc_osc_in <= 1'b1;
    wt(2);
    rc_osc_in <= 1'b0;
    wt(2);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_taps;
    int p;
    for (int t = 0; t < 8; t++) begin
      p = 8 << t;
      wr(`ADDR_COUNT_CONTROL, 32'h08 | t);
      wt(2 * p + p / 2 - 3);
      rdc(`ADDR_COUNT_CONTROL, 32'h02);
    end
  endtask

  task automatic t_wrap;
    wr(`ADDR_AUX_CONTROL, 32'h02);
    wr(`ADDR_COUNT_CONTROL, 32'h08);
    n = 0;
    while (watchdog_tick !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= 2044 && n <= 2056, 1);
    wt(2);
    chk(interval_irq, 1);
    rdc(`ADDR_AUX_CONTROL, 32'h03);
    wr(`ADDR_AUX_CONTROL, 32'h03);
    wt(2);
    chk(interval_irq, 0);
    wr(`ADDR_AUX_CONTROL, 32'h00);
  endtask

  task automatic t_shared;
    wr(`ADDR_COUNT_CONTROL, 32'h18);
    wt(2);
    chk(watchdog_mode, 1);
    rdc(`ADDR_COUNT_CONTROL, 32'h00);
    wr(`ADDR_COUNT_CONTROL, 32'h00);
    wt(2);
    chk(watchdog_mode, 0);
    apb(1'b0, 12'h100, 32'h0, rd, er);
    chk(er, 1);
    chk(rd, 0);
  endtask

  task automatic t_rc;
    wr(`ADDR_COUNT_CONTROL, 32'h28);
    repeat (5) rc_pulse();
    rdc(`ADDR_COUNT_CONTROL, 32'h05);
    wr(`ADDR_AUX_CONTROL, 32'h04);
    wt(2);
    chk(rc_wdt_active, 1);
    chk(periph_tick, 0);
    repeat (3) rc_pulse();
    stop_release <= 1'b1;
    wt(1);
    stop_release <= 1'b0;
    wt(2);
    chk(rc_wdt_active, 0);
    rdc(`ADDR_COUNT_CONTROL, 32'h08);
    wr(`ADDR_COUNT_CONTROL, 32'h08);
  endtask

  task automatic t_pins;
    wr(`ADDR_AUX_CONTROL, 32'h10);
    ext_rc_mode <= 1'b1;
    wt(4);
    n = 0;
    m = 0;
    repeat (40) begin
      @(posedge pclk);
      n += xout_clk;
      m += periph_tick[3];
    end
    chk(n, 20);
    chk(m, 5);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`ADDR_COUNT_CONTROL, 32'h00);
    rdc(`ADDR_AUX_CONTROL, 32'h00);
    t_taps();
    t_wrap();
    t_shared();
    t_rc();
    t_pins();
    final_report();
  end
endmodule // interval_timer_prescaler_tb_top
